// file: rtfc_cfg.svh
`ifndef RTFC_CFG_SVH
`define RTFC_CFG_SVH

// register map, word addresses on the plain register port
`define RTFC_ADDR_W         4
`define RTFC_DATA_W         16
`define RTFC_ADDR_CLK       4'h0
`define RTFC_ADDR_CTL       4'h1
`define RTFC_ADDR_TRG       4'h2
`define RTFC_ADDR_INTF      4'h3
`define RTFC_ADDR_INTE      4'h4
`define RTFC_ADDR_MC_LO     4'h5
`define RTFC_ADDR_MC_HI     4'h6
`define RTFC_ADDR_TC_LO     4'h7
`define RTFC_ADDR_TC_HI     4'h8

// clock register fields
`define RTFC_CLK_DEBUG_RUN      8
`define RTFC_CLK_DIV_HI     5
`define RTFC_CLK_DIV_LO     4
`define RTFC_CLK_SRC_HI     1
`define RTFC_CLK_SRC_LO     0

// control register fields
`define RTFC_CTL_HALF       8
`define RTFC_CTL_CONT       7
`define RTFC_CTL_EXT        6
`define RTFC_CTL_MODE_HI    5
`define RTFC_CTL_MODE_LO    4
`define RTFC_CTL_EN         0

// trigger register fields
`define RTFC_TRG_REF        0
`define RTFC_TRG_SENA       1
`define RTFC_TRG_SENB       2

// flag and enable bit positions
`define RTFC_FLG_W          5
`define RTFC_FLG_REF        0
`define RTFC_FLG_SENA       1
`define RTFC_FLG_SENB       2
`define RTFC_FLG_MCOV       3
`define RTFC_FLG_TCOV       4

// oscillation mode codes
`define RTFC_MODE_DC        2'h0
`define RTFC_MODE_AC        2'h1

// counters
`define RTFC_CNT_W          24
`define RTFC_CNT_MAX        24'hffffff
`define RTFC_CNT_ZERO       24'h000000
`define RTFC_CNT_ONE        24'h000001

// reset values
`define RTFC_RST_DEBUG_RUN      1'h1
`define RTFC_RST_DIV        2'h0
`define RTFC_RST_SRC        2'h0
`define RTFC_RST_FLG        5'h00
`define RTFC_RST_DATA       16'h0000

`endif

// file: rtfc_core.sv
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "rtfc_cfg.svh"

module rtfc_core (
  input  wire logic                    CLK_IN,
  input  wire logic                    RST_IN,
  input  wire logic [`RTFC_ADDR_W-1:0] ADDR_IN,
  input  wire logic [`RTFC_DATA_W-1:0] WR_DATA_IN,
  input  wire logic                    WR_IN,
  input  wire logic                    RD_IN,
  input  wire logic                    DEBUG_MODE_IN,
  input  wire logic                    OSC_CLOCK_IN,
  input  wire logic                    EXT_CLOCK_INPUT_IN,
  output logic      [`RTFC_DATA_W-1:0] RD_DATA_OUT,
  output logic                         IRQ_OUT,
  output logic                         REF_OSC_EN_OUT,
  output logic                         SENA_OSC_EN_OUT,
  output logic                         SENB_OSC_EN_OUT,
  output logic                         AC_MODE_OUT,
  output logic                         OSC_MONITOR_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  rtfc_pkg::rtfc_clk_s    clk_reg_ff;
  rtfc_pkg::rtfc_ctl_s    ctl_reg_ff;
  rtfc_pkg::rtfc_flag_t   flag_ff;
  rtfc_pkg::rtfc_flag_t   inte_ff;
  rtfc_pkg::rtfc_flag_t   flag_set;
  rtfc_pkg::rtfc_flag_t   flag_clr;
  rtfc_pkg::rtfc_phase_e  phase_ff;
  rtfc_pkg::rtfc_phase_e  nxt_phase;
  logic [`RTFC_CNT_W-1:0] meas_ff;
  logic [`RTFC_CNT_W-1:0] nxt_meas;
  logic [`RTFC_CNT_W-1:0] tb_ff;
  logic [`RTFC_CNT_W-1:0] nxt_tb;
  logic [1:0]             pin_sync;
  logic [1:0]             pin_prev_ff;
  logic                   run;
  logic                   active;
  logic                   tb_tick;
  logic                   src_rise;
  logic                   osc_rise;
  logic                   meas_wrap;
  logic                   tb_wrap;
  logic                   stop_ok;
  logic                   wr_clk;
  logic                   wr_ctl;
  logic                   wr_trg;
  logic                   wr_intf;
  logic                   wr_inte;
  logic                   ac_mode;
  logic [`RTFC_DATA_W-1:0] nxt_rd;

  ////////////////////////////////////////////////////////////////////////////
  // pins from the oscillator and the external clock input

  // both pins are asynchronous to CLK_IN, so each passes two flops first
  rtfc_sync #(
    .WIDTH    (2)
  ) u_pin_sync (
    .clk_in   (CLK_IN),
    .rst_in   (RST_IN),
    .async_in ({EXT_CLOCK_INPUT_IN, OSC_CLOCK_IN}),
    .sync_out (pin_sync)
  );

  // edge detection runs on the synchronised copies only
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pin_prev_ff <= 2'h0;
    end else begin
      pin_prev_ff <= pin_sync;
    end
  end

  // limitation: pin clocks must stay below half of CLK_IN to be counted
  assign osc_rise = pin_sync[0] && !pin_prev_ff[0];
  assign src_rise = ctl_reg_ff.ext_clock_mode ? (pin_sync[1] && !pin_prev_ff[1])
                                              : osc_rise;

  ////////////////////////////////////////////////////////////////////////////
  // operating clock supply

  // a cleared debug_run freezes counting, automatic stops and the monitor while the cpu debugs; the oscillator enables stay on
  assign run = ctl_reg_ff.module_enable &&
               !(DEBUG_MODE_IN && !clk_reg_ff.debug_run);

  assign active = (phase_ff != rtfc_pkg::RTFC_IDLE);

  // time base count enable from the selected division of CLK_IN
  rtfc_tbdiv u_tbdiv (
    .clk_in     (CLK_IN),
    .rst_in     (RST_IN),
    .run_in     (run),
    .div_sel_in (clk_reg_ff.clock_divider_select),
    .tick_out   (tb_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  assign wr_clk  = WR_IN && (ADDR_IN == `RTFC_ADDR_CLK);
  assign wr_ctl  = WR_IN && (ADDR_IN == `RTFC_ADDR_CTL);
  assign wr_trg  = WR_IN && (ADDR_IN == `RTFC_ADDR_TRG);
  assign wr_intf = WR_IN && (ADDR_IN == `RTFC_ADDR_INTF);
  assign wr_inte = WR_IN && (ADDR_IN == `RTFC_ADDR_INTE);

  // only code 0x1 selects ac drive; reserved codes fall back to dc drive
  assign ac_mode = (ctl_reg_ff.osc_mode_select == `RTFC_MODE_AC);

  // clock settings only change while the converter is disabled
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      clk_reg_ff.debug_run            <= `RTFC_RST_DEBUG_RUN;
      clk_reg_ff.clock_divider_select <= `RTFC_RST_DIV;
      clk_reg_ff.clock_source_select  <= `RTFC_RST_SRC;
    end else if (wr_clk && !ctl_reg_ff.module_enable) begin
      clk_reg_ff.debug_run            <= WR_DATA_IN[`RTFC_CLK_DEBUG_RUN];
      clk_reg_ff.clock_divider_select <= WR_DATA_IN[`RTFC_CLK_DIV_HI:`RTFC_CLK_DIV_LO];
      clk_reg_ff.clock_source_select  <= WR_DATA_IN[`RTFC_CLK_SRC_HI:`RTFC_CLK_SRC_LO];
    end
  end

  // control register
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ctl_reg_ff <= '0;
    end else if (wr_ctl) begin
      ctl_reg_ff.monitor_half_select <= WR_DATA_IN[`RTFC_CTL_HALF];
      ctl_reg_ff.continuous_osc_en   <= WR_DATA_IN[`RTFC_CTL_CONT];
      ctl_reg_ff.ext_clock_mode      <= WR_DATA_IN[`RTFC_CTL_EXT];
      ctl_reg_ff.osc_mode_select     <= WR_DATA_IN[`RTFC_CTL_MODE_HI:`RTFC_CTL_MODE_LO];
      ctl_reg_ff.module_enable       <= WR_DATA_IN[`RTFC_CTL_EN];
    end
  end

  // interrupt enables
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      inte_ff <= `RTFC_RST_FLG;
    end else if (wr_inte) begin
      inte_ff <= WR_DATA_IN[`RTFC_FLG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer and counters

  // automatic stops apply only outside continuous oscillation
  assign stop_ok   = !ctl_reg_ff.continuous_osc_en;
  assign meas_wrap = active && run && src_rise && (meas_ff == `RTFC_CNT_MAX);
  assign tb_wrap   = active && run && tb_tick && (tb_ff == `RTFC_CNT_MAX);

  // counting, automatic stops, then software writes, which win last
  always_comb begin
    nxt_phase = phase_ff;
    nxt_meas  = meas_ff;
    nxt_tb    = tb_ff;
    flag_set  = `RTFC_RST_FLG;
    if (active && run) begin
      if (src_rise) begin
        nxt_meas = meas_ff + `RTFC_CNT_ONE;
      end
      case (phase_ff)
        rtfc_pkg::RTFC_REF: begin
          if (tb_tick) begin
            nxt_tb = tb_ff + `RTFC_CNT_ONE;
          end
          if (stop_ok && meas_wrap) begin
            flag_set[`RTFC_FLG_REF] = 1'b1;
            nxt_phase = rtfc_pkg::RTFC_IDLE;
          end
          if (stop_ok && tb_wrap) begin
            flag_set[`RTFC_FLG_TCOV] = 1'b1;
            nxt_phase = rtfc_pkg::RTFC_IDLE;
          end
        end
        rtfc_pkg::RTFC_SENA,
        rtfc_pkg::RTFC_SENB: begin
          if (stop_ok && (tb_ff == `RTFC_CNT_ZERO)) begin
            if (phase_ff == rtfc_pkg::RTFC_SENA) begin
              flag_set[`RTFC_FLG_SENA] = 1'b1;
            end else begin
              flag_set[`RTFC_FLG_SENB] = 1'b1;
            end
            nxt_phase = rtfc_pkg::RTFC_IDLE;
          end else if (tb_tick) begin
            nxt_tb = tb_ff - `RTFC_CNT_ONE;
          end
          if (stop_ok && meas_wrap) begin
            flag_set[`RTFC_FLG_MCOV] = 1'b1;
            nxt_phase = rtfc_pkg::RTFC_IDLE;
          end
        end
        default: begin
          nxt_phase = rtfc_pkg::RTFC_IDLE;
        end
      endcase
    end
    // trigger writes are ignored while the converter is disabled
    if (wr_trg && ctl_reg_ff.module_enable) begin
      if (phase_ff == rtfc_pkg::RTFC_IDLE) begin
        if (WR_DATA_IN[`RTFC_TRG_REF]) begin
          nxt_phase = rtfc_pkg::RTFC_REF;
        end else if (WR_DATA_IN[`RTFC_TRG_SENA]) begin
          nxt_phase = rtfc_pkg::RTFC_SENA;
          nxt_meas  = `RTFC_CNT_ZERO;
        end else if (WR_DATA_IN[`RTFC_TRG_SENB] && !ac_mode) begin
          nxt_phase = rtfc_pkg::RTFC_SENB;
          nxt_meas  = `RTFC_CNT_ZERO;
        end
      end else if ((phase_ff == rtfc_pkg::RTFC_REF  && !WR_DATA_IN[`RTFC_TRG_REF])  ||
                   (phase_ff == rtfc_pkg::RTFC_SENA && !WR_DATA_IN[`RTFC_TRG_SENA]) ||
                   (phase_ff == rtfc_pkg::RTFC_SENB && !WR_DATA_IN[`RTFC_TRG_SENB])) begin
        // abort keeps both counters where they stopped
        nxt_phase = rtfc_pkg::RTFC_IDLE;
        nxt_meas  = meas_ff;
        nxt_tb    = tb_ff;
      end
    end
    // software presets of the counters
    if (WR_IN && (ADDR_IN == `RTFC_ADDR_MC_LO)) begin
      nxt_meas[15:0] = WR_DATA_IN;
    end
    if (WR_IN && (ADDR_IN == `RTFC_ADDR_MC_HI)) begin
      nxt_meas[23:16] = WR_DATA_IN[7:0];
    end
    if (WR_IN && (ADDR_IN == `RTFC_ADDR_TC_LO)) begin
      nxt_tb[15:0] = WR_DATA_IN;
    end
    if (WR_IN && (ADDR_IN == `RTFC_ADDR_TC_HI)) begin
      nxt_tb[23:16] = WR_DATA_IN[7:0];
    end
    // disabling the converter drops any running oscillation
    if (!ctl_reg_ff.module_enable) begin
      nxt_phase = rtfc_pkg::RTFC_IDLE;
    end
  end

  // phase register and the oscillator enables that follow it
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      phase_ff        <= rtfc_pkg::RTFC_IDLE;
      REF_OSC_EN_OUT  <= 1'b0;
      SENA_OSC_EN_OUT <= 1'b0;
      SENB_OSC_EN_OUT <= 1'b0;
    end else begin
      phase_ff        <= nxt_phase;
      REF_OSC_EN_OUT  <= (nxt_phase == rtfc_pkg::RTFC_REF);
      SENA_OSC_EN_OUT <= (nxt_phase == rtfc_pkg::RTFC_SENA);
      SENB_OSC_EN_OUT <= (nxt_phase == rtfc_pkg::RTFC_SENB);
    end
  end

  // drive style follows the oscillation mode
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      AC_MODE_OUT <= 1'b0;
    end else begin
      AC_MODE_OUT <= ac_mode;
    end
  end

  // counters
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      meas_ff <= `RTFC_CNT_ZERO;
      tb_ff   <= `RTFC_CNT_ZERO;
    end else begin
      meas_ff <= nxt_meas;
      tb_ff   <= nxt_tb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags and request

  // write-one clears; a set in the same cycle wins over the clear
  assign flag_clr = wr_intf ? WR_DATA_IN[`RTFC_FLG_W-1:0] : `RTFC_RST_FLG;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      flag_ff <= `RTFC_RST_FLG;
    end else begin
      flag_ff <= (flag_ff & ~flag_clr) | flag_set;
    end
  end

  // registered request, one cycle behind the flags
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(flag_ff & inte_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillation clock monitor

  // output holds its level while frozen so the pin keeps its state
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      OSC_MONITOR_OUT <= 1'b0;
    end else if (!active) begin
      OSC_MONITOR_OUT <= 1'b0;
    end else if (run) begin
      if (ctl_reg_ff.monitor_half_select) begin
        OSC_MONITOR_OUT <= OSC_MONITOR_OUT ^ osc_rise;
      end else begin
        OSC_MONITOR_OUT <= pin_sync[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  // counters are read live; a running value may tear between halves
  always_comb begin
    nxt_rd = `RTFC_RST_DATA;
    if (ADDR_IN == `RTFC_ADDR_CLK) begin
      nxt_rd[`RTFC_CLK_DEBUG_RUN] = clk_reg_ff.debug_run;
      nxt_rd[`RTFC_CLK_DIV_HI:`RTFC_CLK_DIV_LO] = clk_reg_ff.clock_divider_select;
      nxt_rd[`RTFC_CLK_SRC_HI:`RTFC_CLK_SRC_LO] = clk_reg_ff.clock_source_select;
    end else if (ADDR_IN == `RTFC_ADDR_CTL) begin
      nxt_rd[`RTFC_CTL_HALF] = ctl_reg_ff.monitor_half_select;
      nxt_rd[`RTFC_CTL_CONT] = ctl_reg_ff.continuous_osc_en;
      nxt_rd[`RTFC_CTL_EXT]  = ctl_reg_ff.ext_clock_mode;
      nxt_rd[`RTFC_CTL_MODE_HI:`RTFC_CTL_MODE_LO] = ctl_reg_ff.osc_mode_select;
      nxt_rd[`RTFC_CTL_EN]   = ctl_reg_ff.module_enable;
    end else if (ADDR_IN == `RTFC_ADDR_TRG) begin
      nxt_rd[`RTFC_TRG_REF]  = (phase_ff == rtfc_pkg::RTFC_REF);
      nxt_rd[`RTFC_TRG_SENA] = (phase_ff == rtfc_pkg::RTFC_SENA);
      nxt_rd[`RTFC_TRG_SENB] = (phase_ff == rtfc_pkg::RTFC_SENB);
    end else if (ADDR_IN == `RTFC_ADDR_INTF) begin
      nxt_rd[`RTFC_FLG_W-1:0] = flag_ff;
    end else if (ADDR_IN == `RTFC_ADDR_INTE) begin
      nxt_rd[`RTFC_FLG_W-1:0] = inte_ff;
    end else if (ADDR_IN == `RTFC_ADDR_MC_LO) begin
      nxt_rd = meas_ff[15:0];
    end else if (ADDR_IN == `RTFC_ADDR_MC_HI) begin
      nxt_rd[7:0] = meas_ff[23:16];
    end else if (ADDR_IN == `RTFC_ADDR_TC_LO) begin
      nxt_rd = tb_ff[15:0];
    end else if (ADDR_IN == `RTFC_ADDR_TC_HI) begin
      nxt_rd[7:0] = tb_ff[23:16];
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      RD_DATA_OUT <= `RTFC_RST_DATA;
    end else if (RD_IN) begin
      RD_DATA_OUT <= nxt_rd;
    end else begin
      RD_DATA_OUT <= `RTFC_RST_DATA;
    end
  end

endmodule // rtfc_core

`default_nettype wire

// file: rtfc_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtfc_cfg.svh"

module rtfc_core_properties (
  input wire logic                    CLK_IN,
  input wire logic                    RST_IN,
  input wire logic [`RTFC_ADDR_W-1:0] ADDR_IN,
  input wire logic [`RTFC_DATA_W-1:0] WR_DATA_IN,
  input wire logic                    WR_IN,
  input wire logic                    RD_IN,
  input wire logic                    DEBUG_MODE_IN,
  input wire logic [`RTFC_DATA_W-1:0] RD_DATA_OUT,
  input wire logic                    IRQ_OUT,
  input wire logic                    REF_OSC_EN_OUT,
  input wire logic                    SENA_OSC_EN_OUT,
  input wire logic                    SENB_OSC_EN_OUT,
  input wire logic                    AC_MODE_OUT,
  input wire logic                    OSC_MONITOR_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  logic [2:0] run;
  logic       trg_wr;
  // running phases, and a trigger register write
  assign run = {SENB_OSC_EN_OUT, SENA_OSC_EN_OUT, REF_OSC_EN_OUT};
  assign trg_wr = WR_IN && (ADDR_IN == `RTFC_ADDR_TRG);
  //////////////////////////////////////////////////////////////////////////////
  chk_one_phase: assert property ($onehot0(run))
    else $error("two phases running");
  // the mode output lags the control register by a cycle, so it must stand two
  chk_ac_no_senb: assert property (
    AC_MODE_OUT && !SENB_OSC_EN_OUT ##1 AC_MODE_OUT |-> !SENB_OSC_EN_OUT)
    else $error("sensor b ran in ac mode");
  chk_monitor_idle: assert property (
    !$past(DEBUG_MODE_IN) && run == 3'h0 && $past(run) == 3'h0 |-> !OSC_MONITOR_OUT)
    else $error("monitor active while idle");
  chk_rd_idle: assert property (!$past(RD_IN) |-> RD_DATA_OUT == 16'h0000)
    else $error("read data outside read slot");
  chk_trig_readback: assert property (
    $past(RD_IN && ADDR_IN == `RTFC_ADDR_TRG) |-> RD_DATA_OUT == {13'h0000, $past(run)})
    else $error("trigger readback differs from phase");
  chk_irq_no_flag: assert property (
    $past(RD_IN && ADDR_IN == `RTFC_ADDR_INTF) && RD_DATA_OUT[4:0] == 5'h00 |-> !IRQ_OUT)
    else $error("irq without flag");
  chk_ref_start: assert property (
    $rose(REF_OSC_EN_OUT) |-> $past(trg_wr && WR_DATA_IN[0]))
    else $error("reference began without trigger");
  chk_sens_start: assert property (
    $rose(SENA_OSC_EN_OUT) |-> $past(trg_wr && WR_DATA_IN[1]))
    else $error("sensor a began without trigger");
  chk_abort_ref: assert property (
    trg_wr && REF_OSC_EN_OUT && !WR_DATA_IN[0] |=> !REF_OSC_EN_OUT)
    else $error("reference not aborted");
  chk_ac_decode: assert property (
    $past(WR_IN && ADDR_IN == `RTFC_ADDR_CTL, 2) && !$past(WR_IN) |->
      AC_MODE_OUT == ($past(WR_DATA_IN[5:4], 2) == 2'h1))
    else $error("mode decode wrong");
  // main scenarios reached
  cov_ref: cover property ($fell(REF_OSC_EN_OUT));
  cov_sena: cover property ($fell(SENA_OSC_EN_OUT));
  cov_irq: cover property ($rose(IRQ_OUT));
endmodule // rtfc_core_properties

bind rtfc_core rtfc_core_properties u_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN),
  .WR_DATA_IN(WR_DATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .DEBUG_MODE_IN(DEBUG_MODE_IN),
  .RD_DATA_OUT(RD_DATA_OUT), .IRQ_OUT(IRQ_OUT), .REF_OSC_EN_OUT(REF_OSC_EN_OUT),
  .SENA_OSC_EN_OUT(SENA_OSC_EN_OUT), .SENB_OSC_EN_OUT(SENB_OSC_EN_OUT),
  .AC_MODE_OUT(AC_MODE_OUT), .OSC_MONITOR_OUT(OSC_MONITOR_OUT));

`default_nettype wire

// file: rtfc_osc_model.sv
`timescale 1ns/100ps
`default_nettype none

// resistor or sensor cr network, or an external pulse source on the input pin
module rtfc_osc_model #(
  parameter int HALF_NS = 125
) (
  input  wire logic run_in,
  input  wire logic use_ext_in,
  output logic      osc_out,
  output logic      ext_out
);
  logic ph = 1'b0;
  // free running, unrelated to the bench clock; it finishes a high half before
  // halting, so no sliver pulse reaches the synchroniser
  always begin
    #(HALF_NS);
    if (run_in || ph) begin
      ph = ~ph;
    end
  end
  // only the selected source swings, idle pins sit low as when pulled down
  assign osc_out = ph && !use_ext_in;
  assign ext_out = ph && use_ext_in;
endmodule // rtfc_osc_model

`default_nettype wire

// file: rtfc_pkg.sv
package rtfc_pkg;

  // conversion phase; the REF and SENA codes equal their trigger bits, the SENB code 2'b11 does not
  typedef enum logic [1:0] {
    RTFC_IDLE = 2'b00,
    RTFC_REF  = 2'b01,
    RTFC_SENA = 2'b10,
    RTFC_SENB = 2'b11
  } rtfc_phase_e;

  // clock control register contents
  typedef struct packed {
    logic       debug_run;
    logic [1:0] clock_divider_select;
    logic [1:0] clock_source_select;
  } rtfc_clk_s;

  // converter control register contents
  typedef struct packed {
    logic       monitor_half_select;
    logic       continuous_osc_en;
    logic       ext_clock_mode;
    logic [1:0] osc_mode_select;
    logic       module_enable;
  } rtfc_ctl_s;

  typedef logic [4:0] rtfc_flag_t;

endpackage

// file: rtfc_sync.sv
`timescale 1ns/100ps
`default_nettype none

// two-flop synchroniser for pin levels entering the CLK_IN domain
module rtfc_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule // rtfc_sync

`default_nettype wire

// file: rtfc_tbdiv.sv
`timescale 1ns/100ps
`default_nettype none

// divider giving the time base count enable: 1/1, 1/2, 1/4 or 1/8 of the clock
module rtfc_tbdiv (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       run_in,
  input  wire logic [1:0] div_sel_in,
  output logic            tick_out
);

  logic [2:0] div_cnt_ff;
  logic [2:0] mask;

  // the mask selects how many low count bits must be all ones
  always_comb begin
    case (div_sel_in)
      2'h0:    mask = 3'h0;
      2'h1:    mask = 3'h1;
      2'h2:    mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end

  // divider stalls while stopped so a frozen phase does not drift
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_cnt_ff <= 3'h0;
      tick_out   <= 1'b0;
    end else begin
      if (run_in) begin
        div_cnt_ff <= div_cnt_ff + 3'h1;
      end
      tick_out <= run_in && ((div_cnt_ff & mask) == mask);
    end
  end

endmodule // rtfc_tbdiv

`default_nettype wire

// file: testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtfc_cfg.svh"

module testbench;
  logic        clk, rst, wr, rd, dbg, irq, ref_en, sena_en, senb_en, ac, mon, osc, ext, use_ext;
  logic        rd_d, seen_mon;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, last_rd, v1, v2;
  logic [16:0] e;
  logic [16:0] exp_q[$];
  int          n_mismatch, n_compared, cyc;

  always #20 clk = ~clk;

  rtfc_core uut (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WR_DATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .DEBUG_MODE_IN(dbg), .OSC_CLOCK_IN(osc), .EXT_CLOCK_INPUT_IN(ext),
    .RD_DATA_OUT(rdata), .IRQ_OUT(irq), .REF_OSC_EN_OUT(ref_en), .SENA_OSC_EN_OUT(sena_en),
    .SENB_OSC_EN_OUT(senb_en), .AC_MODE_OUT(ac), .OSC_MONITOR_OUT(mon));
  rtfc_osc_model u_osc (.run_in(ref_en | sena_en | senb_en), .use_ext_in(use_ext),
    .osc_out(osc), .ext_out(ext));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] x);
    n_compared++;
    if (seen !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, x, seen);
    end
  endtask

  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // read data stand only in the slot after the strobe, so sample mid-cycle
  always @(negedge clk) begin
    if (rd_d) begin
      last_rd = rdata;
      e = exp_q.pop_front();
      if (e[16]) check("read data", rdata, e[15:0]);
    end
    rd_d = rd;
    if (mon === 1'b1) seen_mon = 1'b1;
  end

  // hang guard, well above the longest sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic wrr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rdx(input logic [3:0] a, input logic c, input logic [15:0] x);
    exp_q.push_back({c, x});
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    #1;
  endtask

  task automatic run_wait;
    @(negedge clk);
    for (int i = 0; i < 3000 && (ref_en | sena_en | senb_en); i++) @(negedge clk);
  endtask

  task automatic load(input logic [23:0] mc, input logic [23:0] tc);
    wrr(`RTFC_ADDR_MC_LO, mc[15:0]);
    wrr(`RTFC_ADDR_MC_HI, {8'h00, mc[23:16]});
    wrr(`RTFC_ADDR_TC_LO, tc[15:0]);
    wrr(`RTFC_ADDR_TC_HI, {8'h00, tc[23:16]});
  endtask

  // one phase to its automatic end, then flags, trigger and irq
  task automatic conv(input logic [2:0] trg, input logic [4:0] fl);
    wrr(`RTFC_ADDR_INTF, 16'h001f);
    rdx(`RTFC_ADDR_INTF, 1'b1, 16'h0000);
    wrr(`RTFC_ADDR_TRG, {13'h0000, trg});
    run_wait();
    rdx(`RTFC_ADDR_INTF, 1'b1, {11'h000, fl});
    rdx(`RTFC_ADDR_TRG, 1'b1, 16'h0000);
    check("irq", {15'h0000, irq}, {15'h0000, |fl});
    $display("phase %h done", trg);
  endtask

  initial begin
    {clk, wr, rd, dbg, rd_d, use_ext, seen_mon} = 7'h00;
    rst = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    void'($urandom(32'h46e35b10));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdx(`RTFC_ADDR_CLK, 1'b1, 16'h0100);
    rdx(4'hf, 1'b1, 16'h0000);
    wrr(4'hf, 16'($urandom));
    wrr(`RTFC_ADDR_INTE, 16'h001f);
    wrr(`RTFC_ADDR_CTL, 16'h0001);
    load(24'hffffe0 + 24'($urandom % 16), 24'h000000);
    conv(3'h1, 5'h01);
    rdx(`RTFC_ADDR_MC_LO, 1'b1, 16'h0000);
    rdx(`RTFC_ADDR_TC_LO, 1'b0, 16'h0000);
    check("time base counted", {15'h0000, last_rd != 16'h0000}, 16'h0001);
    conv(3'h2, 5'h02);
    rdx(`RTFC_ADDR_TC_LO, 1'b1, 16'h0000);
    conv(3'h4, 5'h04);
    load(24'h000000, 24'hffff00);
    conv(3'h1, 5'h10);
    load(24'h000000, 24'h000000);
    wrr(`RTFC_ADDR_TRG, 16'h0001);
    repeat (50) @(posedge clk);
    wrr(`RTFC_ADDR_TRG, 16'h0000);
    rdx(`RTFC_ADDR_TC_LO, 1'b0, 16'h0000);
    v1 = last_rd;
    repeat (30) @(posedge clk);
    rdx(`RTFC_ADDR_TC_LO, 1'b1, v1);
    $display("abort done");
    wrr(`RTFC_ADDR_CTL, 16'h0181);
    load(24'hfffff0, 24'h000000);
    seen_mon = 1'b0;
    wrr(`RTFC_ADDR_TRG, 16'h0001);
    repeat (400) @(posedge clk);
    rdx(`RTFC_ADDR_TRG, 1'b1, 16'h0001);
    check("monitor", {15'h0000, seen_mon}, 16'h0001);
    wrr(`RTFC_ADDR_TRG, 16'h0000);
    $display("continuous done");
    wrr(`RTFC_ADDR_CTL, 16'h0011);
    wrr(`RTFC_ADDR_TRG, 16'h0004);
    rdx(`RTFC_ADDR_TRG, 1'b1, 16'h0000);
    check("ac mode", {15'h0000, ac}, 16'h0001);
    load(24'h000000, 24'h000040);
    conv(3'h2, 5'h02);
    wrr(`RTFC_ADDR_CTL, 16'h0041);
    use_ext = 1'b1;
    load(24'hfffff0, 24'h000000);
    conv(3'h1, 5'h01);
    check("dc mode", {15'h0000, ac}, 16'h0000);
    use_ext = 1'b0;
    for (int k = 0; k < 2; k++) begin
      wrr(`RTFC_ADDR_CTL, 16'h0000);
      wrr(`RTFC_ADDR_CLK, k ? 16'h0030 : 16'h0100);
      wrr(`RTFC_ADDR_CTL, 16'h0001);
      load(24'h000000, 24'h000000);
      wrr(`RTFC_ADDR_TRG, 16'h0001);
      dbg <= 1'b1;
      rdx(`RTFC_ADDR_TC_LO, 1'b0, 16'h0000);
      v1 = last_rd;
      repeat (40) @(posedge clk);
      rdx(`RTFC_ADDR_TC_LO, 1'b0, 16'h0000);
      v2 = last_rd;
      check("debug counting", {15'h0000, v1 != v2}, {15'h0000, k == 0});
      dbg <= 1'b0;
      repeat (40) @(posedge clk);
      rdx(`RTFC_ADDR_TC_LO, 1'b0, 16'h0000);
      check("resumed", {15'h0000, last_rd != v2}, 16'h0001);
      wrr(`RTFC_ADDR_TRG, 16'h0000);
    end
    $display("debug done");
    complete_run();
  end
endmodule // testbench

`default_nettype wire
